//--- logic/fault_cfg_defines.vh
// Constants for the drive/input configuration and fault report mask block
`ifndef FAULT_CFG_DEFINES_VH
`define FAULT_CFG_DEFINES_VH

// Register selectors on the configuration write/read port
`define REG_DRIVE_CFG        1'h0
`define REG_FAULT_MASK       1'h1

// drive_and_input_config field positions
`define VREF_SEL_BIT         4
`define PIN_FUNC_BIT         3
`define DRIVE_MSB            2
`define DRIVE_LSB            0

// fault_report_mask_config field positions
`define SPARE_BIT            15
`define SC_MASK_BIT          14
`define OC_MASK_BIT          13
`define GM_ROUTE_MSB         12
`define GM_ROUTE_LSB         11
`define PS_TSD_EN_BIT        8
`define GD_TSD_MASK_BIT      7

// Reset values
`define DRIVE_CFG_RESET      16'h0010
`define FAULT_MASK_RESET     16'h8940

// Gate monitor routing codes
`define GM_MASKED            2'h0
`define GM_TO_PRIMARY        2'h1
`define GM_TO_SECONDARY      2'h2
`define GM_LIVE_STATE        2'h3

// Segment enable patterns (six segments, thirds and sixths)
`define SEG_ALL              6'h3F
`define SEG_THIRD            6'h03
`define SEG_SIXTH            6'h01

`endif

//--- logic/gate_driver_config_fault_mask_regs.v
// Drive strength, analog pin function and fault report mask registers
`include "fault_cfg_defines.vh"

module gate_driver_config_fault_mask_regs (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        cfg_wr_en,
  input  wire        cfg_sel,
  input  wire [15:0] cfg_wdata,
  output reg  [15:0] cfg_rdata,
  input  wire        active_mode,
  input  wire        config_check_disable,
  input  wire        analog_pin_five,
  input  wire        analog_pin_six,
  input  wire        short_circuit_fault,
  input  wire        overcurrent_fault,
  input  wire        gate_monitor_fault,
  input  wire        gate_voltage_state,
  input  wire        switch_thermal_fault,
  input  wire        driver_thermal_fault,
  output reg         vref_external,
  output reg         short_circuit_enable_in,
  output reg         short_circuit_command_in,
  output reg         converter_pin_five,
  output reg         converter_pin_six,
  output reg         pin_five_pullup_on,
  output reg  [5:0]  segment_enable,
  output reg  [15:0] secondary_config_checksum,
  output reg         config_check_fault,
  output reg         secondary_shutdown,
  output reg         primary_alarm_n,
  output reg         secondary_alarm_n
);

  reg  [15:0] drive_and_input_config_r;
  reg  [15:0] fault_report_mask_config_r;
  reg  [1:0]  pin5_sync_r;
  reg  [1:0]  pin6_sync_r;
  reg  [5:0]  flt_sync1_r;
  reg  [5:0]  flt_sync2_r;
  wire        analog_pin_function_select;
  wire [2:0]  drive_strength_select;
  wire [1:0]  gate_monitor_report_route;
  wire        short_circuit_report_mask;
  wire        overcurrent_report_mask;
  wire        switch_thermal_report_enable;
  wire        driver_thermal_report_mask;
  wire        drive_change;
  reg  [5:0]  segment_nxt;
  reg         primary_nxt;
  reg         secondary_nxt;

  assign analog_pin_function_select =
    drive_and_input_config_r[`PIN_FUNC_BIT];
  assign drive_strength_select =
    drive_and_input_config_r[`DRIVE_MSB:`DRIVE_LSB];
  assign gate_monitor_report_route =
    fault_report_mask_config_r[`GM_ROUTE_MSB:`GM_ROUTE_LSB];
  assign short_circuit_report_mask =
    fault_report_mask_config_r[`SC_MASK_BIT];
  assign overcurrent_report_mask = fault_report_mask_config_r[`OC_MASK_BIT];
  assign switch_thermal_report_enable =
    fault_report_mask_config_r[`PS_TSD_EN_BIT];
  assign driver_thermal_report_mask =
    fault_report_mask_config_r[`GD_TSD_MASK_BIT];

  // Checksum image of both registers, spare bit included, kept in a
  // flop like every data output; a write never starts a check by itself
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secondary_config_checksum <= `DRIVE_CFG_RESET ^ `FAULT_MASK_RESET;
    end else begin
      secondary_config_checksum <=
        drive_and_input_config_r ^ fault_report_mask_config_r;
    end
  end

  // A drive change in active mode with checking still on is a config fault
  // The flag rises at the write edge, so the host sees it as soon as the write completes
  assign drive_change = cfg_wr_en && (cfg_sel == `REG_DRIVE_CFG) &&
    (cfg_wdata[`DRIVE_MSB:`DRIVE_LSB] != drive_strength_select);

  // Register writes; active mode never blocks them
  // Whole words are stored; bits with no function here still read back
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_and_input_config_r   <= `DRIVE_CFG_RESET;
      fault_report_mask_config_r <= `FAULT_MASK_RESET;
    end else if (cfg_wr_en) begin
      if (cfg_sel == `REG_DRIVE_CFG)
        drive_and_input_config_r <= cfg_wdata;
      else
        fault_report_mask_config_r <= cfg_wdata;
    end
  end

  // Sticky config check fault; a spare-only write never raises it
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_check_fault <= 1'b0;
    end else if (drive_change && active_mode && !config_check_disable) begin
      config_check_fault <= 1'b1;
    end
  end

  // Two-stage synchronisers for pins and fault levels from other domains
  // Levels only: a fault pulse shorter than a clock period may be missed
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin5_sync_r <= 2'h0;
      pin6_sync_r <= 2'h0;
      flt_sync1_r <= 6'h00;
      flt_sync2_r <= 6'h00;
    end else begin
      pin5_sync_r <= {pin5_sync_r[0], analog_pin_five};
      pin6_sync_r <= {pin6_sync_r[0], analog_pin_six};
      flt_sync1_r <= {driver_thermal_fault, switch_thermal_fault,
                      gate_voltage_state, gate_monitor_fault,
                      overcurrent_fault, short_circuit_fault};
      flt_sync2_r <= flt_sync1_r;
    end
  end

  // Segment pattern from drive code; codes above one all map to a sixth
  always @* begin
    case (drive_strength_select)
      3'h0:    segment_nxt = `SEG_ALL;
      3'h1:    segment_nxt = `SEG_THIRD;
      default: segment_nxt = `SEG_SIXTH;
    endcase
  end

  // Alarm combining; spare bit deliberately not read here
  // Gate monitor code three shows the live gate state, fault or not
  always @* begin
    primary_nxt   = 1'b1;
    secondary_nxt = 1'b1;
    if (flt_sync2_r[0] && !short_circuit_report_mask)
      primary_nxt = 1'b0;
    if (flt_sync2_r[1] && !overcurrent_report_mask)
      primary_nxt = 1'b0;
    if (flt_sync2_r[4] && switch_thermal_report_enable)
      primary_nxt = 1'b0;
    if (flt_sync2_r[5] && !driver_thermal_report_mask)
      primary_nxt = 1'b0;
    case (gate_monitor_report_route)
      `GM_TO_PRIMARY: begin
        if (flt_sync2_r[2])
          primary_nxt = 1'b0;
      end
      `GM_TO_SECONDARY: begin
        if (flt_sync2_r[2])
          secondary_nxt = 1'b0;
      end
      `GM_LIVE_STATE: begin
        secondary_nxt = ~flt_sync2_r[3];
      end
      default: begin
        secondary_nxt = 1'b1;
      end
    endcase
  end

  // Registered outputs
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vref_external            <= 1'b1;
      short_circuit_enable_in  <= 1'b0;
      short_circuit_command_in <= 1'b0;
      converter_pin_five       <= 1'b0;
      converter_pin_six        <= 1'b0;
      pin_five_pullup_on       <= 1'b0;
      segment_enable           <= `SEG_ALL;
      secondary_shutdown       <= 1'b0;
      primary_alarm_n          <= 1'b1;
      secondary_alarm_n        <= 1'b1;
      cfg_rdata                <= 16'h0000;
    end else begin
      vref_external <= drive_and_input_config_r[`VREF_SEL_BIT];
      if (!analog_pin_function_select) begin
        short_circuit_enable_in  <= pin5_sync_r[1];
        short_circuit_command_in <= pin6_sync_r[1];
        converter_pin_five       <= 1'b0;
        converter_pin_six        <= 1'b0;
      end else begin
        short_circuit_enable_in  <= 1'b0;
        short_circuit_command_in <= 1'b0;
        converter_pin_five       <= pin5_sync_r[1];
        converter_pin_six        <= pin6_sync_r[1];
      end
      // The pull-up only serves the converter use of pin five
      pin_five_pullup_on <= analog_pin_function_select;
      segment_enable     <= segment_nxt;
      // Shutdown ignores the report mask entirely
      secondary_shutdown <= flt_sync2_r[5];
      primary_alarm_n    <= primary_nxt;
      secondary_alarm_n  <= secondary_nxt;
      // Read data trails the select by one cycle; there is no wait state
      cfg_rdata <= (cfg_sel == `REG_DRIVE_CFG) ?
        drive_and_input_config_r : fault_report_mask_config_r;
    end
  end

endmodule // gate_driver_config_fault_mask_regs

//--- dv/cfg_host.sv
// Host model that writes and reads the configuration port
module cfg_host (
  input  wire logic        sys_clk,
  input  wire logic [15:0] cfg_rdata,
  output logic             cfg_wr_en,
  output logic             cfg_sel,
  output logic [15:0]      cfg_wdata,
  output logic             config_check_disable
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cfg_wr_en, cfg_sel, cfg_wdata, config_check_disable} = '0;
  // One-cycle strobe; data is inverted after it so nothing stale is reused
  task automatic wr(input logic s, input logic [15:0] d);
    @(posedge sys_clk) #1 {cfg_sel, cfg_wdata, cfg_wr_en} = {s, d, 1'b1};
    @(posedge sys_clk) #1 {cfg_wr_en, cfg_wdata} = {1'b0, ~d};
  endtask
  // Readback lands one edge after the select has settled
  task automatic rd(input logic s, output logic [15:0] d);
    @(posedge sys_clk) #1 cfg_sel = s;
    repeat (2) @(posedge sys_clk);
    #1 d = cfg_rdata;
  endtask
  // Live drive changes must be preceded by disabling the
  task automatic guard(input logic g);
    @(posedge sys_clk) #1 config_check_disable = g;
  endtask
endmodule // cfg_host

//--- dv/gate_driver_config_fault_mask_regs_chk.sv
// Assertion checker bound to the drive and fault mask register block
module cfg_mask_chk (
  input wire logic        sys_clk, reset_n, cfg_wr_en, cfg_sel,
  input wire logic [15:0] cfg_wdata,
  input wire logic        active_mode, config_check_disable,
  input wire logic        short_circuit_fault, driver_thermal_fault,
  input wire logic        vref_external, pin_five_pullup_on,
  input wire logic [5:0]  segment_enable,
  input wire logic        config_check_fault, secondary_shutdown,
  input wire logic        primary_alarm_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mask_r;
  logic [2:0]  drive_r;
  // Shadow copies of stored fields, taken at the write edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) {mask_r, drive_r} <= {16'h8940, 3'h0};
    else if (cfg_wr_en && cfg_sel) mask_r <= cfg_wdata;
    else if (cfg_wr_en) drive_r <= cfg_wdata[2:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence drv_wr;
    cfg_wr_en && !cfg_sel;
  endsequence
  chk_vref_follow: assert property (drv_wr |-> ##2
    vref_external == $past(cfg_wdata[4], 2)) else $error("vref wrong");
  chk_seg_full: assert property (drv_wr and cfg_wdata[2:0] == 3'h0
    |-> ##2 segment_enable == 6'h3f) else $error("segments not all on");
  chk_seg_third: assert property (drv_wr and cfg_wdata[2:0] == 3'h1
    |-> ##2 segment_enable == 6'h03) else $error("segments not third");
  chk_seg_sixth: assert property (drv_wr and cfg_wdata[2:1] != 0
    |-> ##2 segment_enable == 6'h01) else $error("segments not sixth");
  chk_pullup_off: assert property (drv_wr and !cfg_wdata[3]
    |-> ##2 !pin_five_pullup_on) else $error("pull-up on");
  chk_live_accept: assert property (drv_wr and config_check_disable
    and !config_check_fault |=> !config_check_fault) else $error("fault");
  chk_check_trip: assert property (drv_wr and active_mode
    and !config_check_disable and cfg_wdata[2:0] != drive_r
    |=> config_check_fault) else $error("check fault missing");
  chk_sc_alarm: assert property ((short_circuit_fault
    && !mask_r[14])[*4] |-> !primary_alarm_n) else $error("alarm high");
  chk_thermal_off: assert property (driver_thermal_fault[*4]
    |-> secondary_shutdown) else $error("no shutdown");
endmodule // cfg_mask_chk
bind gate_driver_config_fault_mask_regs cfg_mask_chk chk (.*);

//--- dv/tb_gate_driver_config_fault_mask_regs.sv
// Self-checking bench for the drive and fault mask register block
module tb_gate_driver_config_fault_mask_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, reset_n = 0, active_mode = 0, gate_voltage_state = 0;
  logic analog_pin_five = 0, analog_pin_six = 0, short_circuit_fault = 0;
  logic overcurrent_fault = 0, gate_monitor_fault = 0;
  logic switch_thermal_fault = 0, driver_thermal_fault = 0;
  logic cfg_wr_en, cfg_sel, config_check_disable, vref_external;
  logic [15:0] cfg_wdata, cfg_rdata, secondary_config_checksum, rv;
  logic short_circuit_enable_in, short_circuit_command_in;
  logic converter_pin_five, converter_pin_six, pin_five_pullup_on;
  logic config_check_fault, secondary_shutdown;
  logic primary_alarm_n, secondary_alarm_n;
  logic [5:0] segment_enable;
  int n_fail = 0, checks = 0, cyc = 0;
  // Alarm table: mask word, fault index, {primary_n, secondary_n, shutdown}
  logic [15:0] mk [11] = '{16'h2080, 16'h6080, 16'h4080, 16'h6880,
    16'h7080, 16'h6080, 16'h7880, 16'h6180, 16'h6080, 16'h6080, 16'h6000};
  int fi [11] = '{0, 0, 1, 2, 2, 2, 2, 3, 3, 4, 4};
  logic [2:0] ex [11] = '{3'h2, 3'h6, 3'h2, 3'h2, 3'h4, 3'h6, 3'h4,
    3'h2, 3'h6, 3'h7, 3'h3};
  always #5 sys_clk = ~sys_clk;
  cfg_host host (.*);
  gate_driver_config_fault_mask_regs dut (.*);
  task automatic cmp(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Cut a hang short; the sequence needs under two hundred cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    tick(20);
    reset_n = 1;
    host.rd(1'b0, rv); cmp(rv, 16'h0010);
    host.rd(1'b1, rv); cmp(rv, 16'h8940);
    cmp(segment_enable, 6'h3f);
    cmp(vref_external, 1'b1);
    $display("reset test done");
    active_mode = 1;
    host.guard(1'b1);
    for (int c = 7; c >= 0; c--) begin
      host.wr(1'b0, {13'h0, c[2:0]});
      tick(1);
      cmp(segment_enable, c == 0 ? 6'h3f : c == 1 ? 6'h03 : 6'h01);
    end
    cmp({vref_external, config_check_fault}, 2'h0);
    $display("drive test done");
    {analog_pin_five, analog_pin_six} = 2'h2;
    host.wr(1'b0, 16'h0000);
    tick(3);
    cmp({short_circuit_enable_in, short_circuit_command_in, converter_pin_five,
      converter_pin_six, pin_five_pullup_on}, 5'h10);
    host.wr(1'b0, 16'h0018);
    tick(3);
    cmp({short_circuit_enable_in, short_circuit_command_in, converter_pin_five,
      converter_pin_six, pin_five_pullup_on}, 5'h05);
    cmp(vref_external, 1'b1);
    host.guard(1'b0);
    host.wr(1'b0, 16'h0002);
    cmp(config_check_fault, 1'b1);
    $display("pin and check test done");
    gate_voltage_state = 1;
    for (int i = 0; i < 11; i++) begin
      host.wr(1'b1, mk[i]);
      {short_circuit_fault, overcurrent_fault, gate_monitor_fault,
        switch_thermal_fault, driver_thermal_fault} = 5'h10 >> fi[i];
      tick(4);
      cmp({primary_alarm_n, secondary_alarm_n, secondary_shutdown}, ex[i]);
      {short_circuit_fault, overcurrent_fault, gate_monitor_fault,
        switch_thermal_fault, driver_thermal_fault} = 5'h00;
      tick(4);
    end
    $display("alarm test done");
    host.wr(1'b1, 16'he000);
    tick(1);
    cmp(secondary_config_checksum, 16'he002);
    cmp(segment_enable, 6'h01);
    host.rd(1'b1, rv); cmp(rv, 16'he000);
    $display("spare test done");
    reset_n = 0;
    tick(2);
    reset_n = 1;
    cmp({vref_external, config_check_fault}, 2'h2);
    cmp(segment_enable, 6'h3f);
    cmp(secondary_config_checksum, 16'h8950);
    host.rd(1'b1, rv); cmp(rv, 16'h8940);
    $display("second reset test done");
    summarize();
  end
endmodule // tb_gate_driver_config_fault_mask_regs
